// ### src/sbd_cfg.svh
// constants for the service bus debug access block
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH
`define SBD_SLV_DBG 4'h1
`define SBD_SLV_SYS 4'h4
`define SBD_SLV_SYS_ALT 4'h5
`define SBD_SLV_MSU 4'h6
`define SBD_SZ_BYTE 2'h0
`define SBD_SZ_HALF 2'h1
`define SBD_SZ_WORD 2'h2
`define SBD_SEC_CC_LO 36'h100000110
`define SBD_SEC_CC_HI 36'h100000118
`define SBD_SEC_UP_LO 36'h580800000
`define SBD_SEC_UP_HI 36'h581000000
`define SBD_OFF_DC 12'h008
`define SBD_OFF_DPC 12'h040
`define SBD_OFF_DINST 12'h104
`define SBD_OFF_TODBG 12'h110
`define SBD_OFF_TOCPU 12'h114
`define SBD_OFF_CCSTAT 12'h118
`define SBD_OFF_PBP0 12'h200
`define SBD_OFF_DBP0 12'h240
`define SBD_NUM_PBP 6
`define SBD_NUM_DBP 2
`define SBD_DC_MM 0
`define SBD_DC_BRK 1
`define SBD_DC_RES 2
`define SBD_DC_AUXEN 3
`define SBD_DC_AUXLOC 4
`define SBD_DC_DBPEN0 8
`define SBD_DC_IRQRD 10
`define SBD_DC_IRQWR 11
`define SBD_DC_CLKEN 12
`define SBD_DC_RESET 32'h00001000
`endif

// ### src/sbd_debug.sv
// debug access bridge, slave decode, security filter and on-chip debug regs
// What this block does
// - service bus carries a 36-bit address to select slave locations.
// - accesses may be byte, halfword or word sized.
// - top four address bits pick the slave, low 32 go to it.
// - slave 1 is debug regs, 4 system bus space, 6 memory service unit.
// - slave 5 aliases the system bus; slave 0 and others unused.
// - bridge crosses debugger clock to system clock; access needs running clock.
// - debugger activity requests the system clock without leaving sleep.
// - when secure, only the comm channel window stays read/write.
// - when secure, user page is read-only; everything else is blocked.
// - both comm channel registers remain reachable while secure.
// - comm channel is two registers with handshake, used by cpu and debugger.
// - interrupt on debugger read of cpu channel or write of debugger channel.
// - debugger write requesting unconditional break halts the cpu at once.
// - six program breakpoints and two data breakpoints.
// - data breakpoint fires on read or write of its address.
// - breakpoint puts cpu in debug mode and sets the debug flag.
// - in halt mode each debug instruction write issues one instruction.
// - monitor bit makes breakpoints fetch from the debug exception vector.
// - debug program counter register is readable while the cpu runs.
// - debug clock enabled at reset, synchronous, may run through sleep.
// - cpu reads and writes debug registers directly over its port.
//
// Chosen here: strobed register access and the register addresses.
`include "sbd_cfg.svh"
module sbd_debug (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic dbg_clk,
  input wire logic dbg_req,
  input wire logic [35:0] dbg_addr,
  input wire logic dbg_write,
  input wire logic [1:0] dbg_size,
  input wire logic [31:0] dbg_wdata,
  output logic dbg_ack,
  output logic dbg_err,
  output logic [31:0] dbg_rdata,
  output logic clk_wake,
  output logic ext_req,
  output logic ext_msu,
  output logic [31:0] ext_addr,
  output logic ext_write,
  output logic [1:0] ext_size,
  output logic [31:0] ext_wdata,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  input wire logic flash_secure,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] cpu_pc,
  input wire logic cpu_pc_valid,
  input wire logic [31:0] cpu_daddr,
  input wire logic cpu_dvalid,
  input wire logic cpu_dbg_exit,
  output logic cpu_dbg_mode,
  output logic cpu_monitor,
  output logic cpu_dbg_enter,
  output logic [31:0] cpu_inst,
  output logic cpu_inst_valid,
  output logic comm_irq,
  output logic aux_en,
  output logic aux_loc,
  output logic debug_logic_clock_en
);
  sbd_pkg::sbd_state_s q;
  sbd_pkg::sbd_state_s d;

  function automatic logic [31:0] rd_reg(input sbd_pkg::sbd_state_s s,
                                         input logic [11:0] off);
    logic [31:0] r;
    r = 32'h0;
    case (off)
      `SBD_OFF_DC: r = s.dc;
      `SBD_OFF_DPC: r = s.dpc;
      `SBD_OFF_DINST: r = s.dinst;
      `SBD_OFF_TODBG: r = s.to_dbg;
      `SBD_OFF_TOCPU: r = s.to_cpu;
      `SBD_OFF_CCSTAT: r = {30'h0, s.emu_full, s.cpu_full};
      default: begin
        if (off[11:5] == `SBD_OFF_PBP0 >> 5 && off[4:2] < 3'h6) begin
          r = s.pbp[off[4:2]];
        end else if (off[11:3] == `SBD_OFF_DBP0 >> 3) begin
          r = s.dbp[off[2]];
        end
      end
    endcase
    return r;
  endfunction

  // byte lanes follow the low address bits
  function automatic logic [31:0] lane_mask(input logic [1:0] sz,
                                            input logic [1:0] a);
    logic [31:0] m;
    m = 32'hffffffff;
    if (sz == `SBD_SZ_BYTE) begin
      m = 32'h000000ff << (8 * a);
    end else if (sz == `SBD_SZ_HALF) begin
      m = 32'h0000ffff << (16 * a[1]);
    end
    return m;
  endfunction

  logic [3:0] slv;
  logic slv_ok;
  logic misalign;
  logic sec_ok;
  logic req_err;
  logic clk_edge;
  logic [5:0] pbp_hit;
  logic [1:0] dbp_hit;

  assign slv = q.cap_addr[35:32];
  assign slv_ok = slv == `SBD_SLV_DBG || slv == `SBD_SLV_SYS ||
                  slv == `SBD_SLV_SYS_ALT || slv == `SBD_SLV_MSU;
  assign misalign = (q.cap_sz == `SBD_SZ_HALF && q.cap_addr[0]) ||
                    (q.cap_sz == `SBD_SZ_WORD && q.cap_addr[1:0] != 2'h0) ||
                    q.cap_sz == 2'h3;
  assign sec_ok = !flash_secure ||
                  (q.cap_addr >= `SBD_SEC_CC_LO &&
                   q.cap_addr <= `SBD_SEC_CC_HI) ||
                  (!q.cap_wr && q.cap_addr >= `SBD_SEC_UP_LO &&
                   q.cap_addr < `SBD_SEC_UP_HI);
  assign req_err = !slv_ok || misalign || !sec_ok;
  // only the second stage and its delayed copy feed the edge detector
  assign clk_edge = q.s2_clk && !q.s3_clk;

  always_comb begin
    for (int i = 0; i < `SBD_NUM_PBP; i++) begin
      pbp_hit[i] = q.pbp[i][0] && cpu_pc_valid &&
                   q.pbp[i][31:1] == cpu_pc[31:1];
    end
    for (int i = 0; i < `SBD_NUM_DBP; i++) begin
      dbp_hit[i] = q.dc[`SBD_DC_DBPEN0 + i] && cpu_dvalid &&
                   q.dbp[i] == cpu_daddr;
    end
  end

  always_comb begin
    logic [1:0] wr_v;
    logic [1:0] rd_v;
    logic [1:0][11:0] off_v;
    logic [1:0][31:0] wd_v;
    logic [1:0][31:0] mk_v;
    logic regs_acc;
    logic brk;
    logic res;
    logic [31:0] nv;
    d = q;
    wr_v = 2'h0;
    rd_v = 2'h0;
    off_v[0] = reg_addr;
    off_v[1] = q.cap_addr[11:0];
    wd_v[0] = reg_wdata;
    wd_v[1] = q.cap_wd;
    mk_v[0] = 32'hffffffff;
    mk_v[1] = lane_mask(q.cap_sz, q.cap_addr[1:0]);
    regs_acc = 1'b0;
    brk = 1'b0;
    res = 1'b0;
    nv = 32'h0;
    if (ce) begin
      // all link pins pass two flops before use, except dbg_req, which feeds clk_wake raw
      d.s1_clk = dbg_clk;
      d.s2_clk = q.s1_clk;
      d.s3_clk = q.s2_clk;
      d.s1_req = dbg_req;
      d.s2_req = q.s1_req;
      d.s1_addr = dbg_addr;
      d.s2_addr = q.s1_addr;
      d.s1_wr = dbg_write;
      d.s2_wr = q.s1_wr;
      d.s1_sz = dbg_size;
      d.s2_sz = q.s1_sz;
      d.s1_wd = dbg_wdata;
      d.s2_wd = q.s1_wd;
      d.inst_v = 1'b0;
      d.enter = 1'b0;
      d.irq = 1'b0;
      d.reg_rdata = 32'h0;
      d.dpc = cpu_pc_valid ? cpu_pc : q.dpc;
      case (q.st)
        sbd_pkg::ST_IDLE: begin
          // fields are stable at the link clock rising edge
          if (clk_edge && q.s2_req) begin
            d.cap_addr = q.s2_addr;
            d.cap_wr = q.s2_wr;
            d.cap_sz = q.s2_sz;
            d.cap_wd = q.s2_wd;
            d.st = sbd_pkg::ST_EXEC;
          end
        end
        sbd_pkg::ST_EXEC: begin
          d.err = req_err;
          if (req_err) begin
            d.ack = 1'b1;
            d.rdata = 32'h0;
            d.st = sbd_pkg::ST_ACK;
          end else if (slv == `SBD_SLV_DBG) begin
            regs_acc = 1'b1;
            d.rdata = q.cap_wr ? 32'h0 : rd_reg(q, q.cap_addr[11:0]);
            d.ack = 1'b1;
            d.st = sbd_pkg::ST_ACK;
          end else begin
            d.ext_req = 1'b1;
            d.ext_msu = slv == `SBD_SLV_MSU;
            d.st = sbd_pkg::ST_EXT;
          end
        end
        sbd_pkg::ST_EXT: begin
          // waits as long as the slave needs; no access without sys_clk
          if (ext_ack) begin
            d.ext_req = 1'b0;
            d.rdata = q.cap_wr ? 32'h0 : ext_rdata;
            d.ack = 1'b1;
            d.st = sbd_pkg::ST_ACK;
          end
        end
        sbd_pkg::ST_ACK: begin
          if (!q.s2_req) begin
            d.ack = 1'b0;
            d.st = sbd_pkg::ST_IDLE;
          end
        end
        default: d.st = sbd_pkg::ST_IDLE;
      endcase
      // source 0 is the cpu port, source 1 the debugger
      wr_v[0] = reg_wr;
      rd_v[0] = reg_rd;
      wr_v[1] = regs_acc && q.cap_wr;
      rd_v[1] = regs_acc && !q.cap_wr;
      if (reg_rd) begin
        d.reg_rdata = rd_reg(q, reg_addr);
      end
      // reads clear first so a same-cycle fill wins
      if (rd_v[1] && off_v[1] == `SBD_OFF_TODBG) begin
        d.cpu_full = 1'b0;
        d.irq = q.dc[`SBD_DC_IRQRD];
      end
      if (rd_v[0] && off_v[0] == `SBD_OFF_TOCPU) begin
        d.emu_full = 1'b0;
      end
      for (int s = 0; s < 2; s++) begin
        if (wr_v[s]) begin
          case (off_v[s])
            `SBD_OFF_DC: begin
              nv = (d.dc & ~mk_v[s]) | (wd_v[s] & mk_v[s]);
              brk = brk || nv[`SBD_DC_BRK];
              res = res || nv[`SBD_DC_RES];
              nv[`SBD_DC_BRK] = 1'b0;
              nv[`SBD_DC_RES] = 1'b0;
              d.dc = nv;
            end
            `SBD_OFF_DINST: begin
              d.dinst = (d.dinst & ~mk_v[s]) | (wd_v[s] & mk_v[s]);
              d.inst_v = q.dmode && !q.mon;
            end
            `SBD_OFF_TODBG: begin
              d.to_dbg = (d.to_dbg & ~mk_v[s]) | (wd_v[s] & mk_v[s]);
              d.cpu_full = 1'b1;
            end
            `SBD_OFF_TOCPU: begin
              d.to_cpu = (d.to_cpu & ~mk_v[s]) | (wd_v[s] & mk_v[s]);
              d.emu_full = 1'b1;
              d.irq = d.irq || q.dc[`SBD_DC_IRQWR];
            end
            default: begin
              if (off_v[s][11:5] == `SBD_OFF_PBP0 >> 5 &&
                  off_v[s][4:2] < 3'h6) begin
                d.pbp[off_v[s][4:2]] = (d.pbp[off_v[s][4:2]] & ~mk_v[s]) |
                                       (wd_v[s] & mk_v[s]);
              end else if (off_v[s][11:3] == `SBD_OFF_DBP0 >> 3) begin
                d.dbp[off_v[s][2]] = (d.dbp[off_v[s][2]] & ~mk_v[s]) |
                                     (wd_v[s] & mk_v[s]);
              end
            end
          endcase
        end
      end
      // entry only acts while running; exit only acts while already halted
      if (!q.dmode && (brk || pbp_hit != 6'h0 || dbp_hit != 2'h0)) begin
        d.dmode = 1'b1;
        d.mon = q.dc[`SBD_DC_MM];
        d.enter = 1'b1;
      end else if (q.dmode && (cpu_dbg_exit || res)) begin
        d.dmode = 1'b0;
        d.mon = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.dc <= `SBD_DC_RESET;
    end else begin
      q <= d;
    end
  end

  assign dbg_ack = q.ack;
  assign dbg_err = q.err;
  assign dbg_rdata = q.rdata;
  // raw pin on purpose: sys_clk may be stopped and cannot sample it
  assign clk_wake = dbg_req || q.st != sbd_pkg::ST_IDLE;
  assign ext_req = q.ext_req;
  assign ext_msu = q.ext_msu;
  assign ext_addr = q.cap_addr[31:0];
  assign ext_write = q.cap_wr;
  assign ext_size = q.cap_sz;
  assign ext_wdata = q.cap_wd;
  assign reg_rdata = q.reg_rdata;
  assign cpu_dbg_mode = q.dmode;
  assign cpu_monitor = q.mon;
  assign cpu_dbg_enter = q.enter;
  assign cpu_inst = q.dinst;
  assign cpu_inst_valid = q.inst_v;
  assign comm_irq = q.irq;
  assign aux_en = q.dc[`SBD_DC_AUXEN];
  assign aux_loc = q.dc[`SBD_DC_AUXLOC];
  assign debug_logic_clock_en = q.dc[`SBD_DC_CLKEN];

  sequence s_ext_done;
    ce && q.ext_req && ext_ack;
  endsequence

  a_ext_completes: assert property (@(posedge sys_clk) disable iff (reset)
    s_ext_done |=> q.ack && !q.ext_req && q.st == sbd_pkg::ST_ACK)
    else $error("external access did not complete");
  a_ext_held: assert property (@(posedge sys_clk) disable iff (reset)
    ce && q.ext_req && !ext_ack |=> q.ext_req)
    else $error("external request dropped early");
  a_slave_route: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(q.ext_req) |-> q.ext_msu == (slv == `SBD_SLV_MSU) &&
                         slv != `SBD_SLV_DBG)
    else $error("wrong slave routing");
  a_unalloc_err: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(q.ack) && !slv_ok |-> q.err)
    else $error("unallocated slave not refused");
  a_misalign_err: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(q.ack) && q.cap_sz == `SBD_SZ_WORD && q.cap_addr[1:0] != 2'h0
    |-> q.err)
    else $error("misaligned word not refused");
  a_secure_block: assert property (@(posedge sys_clk) disable iff (reset)
    ce && q.st == sbd_pkg::ST_EXEC && flash_secure && q.cap_wr &&
    slv == `SBD_SLV_SYS |=> q.err && q.ack && !q.ext_req)
    else $error("secure write not blocked");
  a_pbp_halt: assert property (@(posedge sys_clk) disable iff (reset)
    ce && !q.dmode && pbp_hit != 6'h0 |=> q.dmode && q.enter)
    else $error("program breakpoint did not halt");
  a_dpc_track: assert property (@(posedge sys_clk) disable iff (reset)
    ce && cpu_pc_valid |=> q.dpc == $past(cpu_pc))
    else $error("debug pc not tracking");
  a_inst_issue: assert property (@(posedge sys_clk) disable iff (reset)
    q.inst_v |-> q.dmode && !q.mon)
    else $error("instruction issued outside halt mode");
  a_clk_reset: assert property (@(posedge sys_clk)
    $fell(reset) |-> debug_logic_clock_en && !cpu_dbg_mode)
    else $error("debug clock not enabled at reset");
endmodule

// ### src/sbd_pkg.sv
// types for the service bus debug access block
package sbd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_EXT, ST_ACK} sbd_st_e;
  typedef struct packed {
    sbd_st_e st;
    logic s1_clk;
    logic s2_clk;
    logic s3_clk;
    logic s1_req;
    logic s2_req;
    logic [35:0] s1_addr;
    logic [35:0] s2_addr;
    logic s1_wr;
    logic s2_wr;
    logic [1:0] s1_sz;
    logic [1:0] s2_sz;
    logic [31:0] s1_wd;
    logic [31:0] s2_wd;
    logic [35:0] cap_addr;
    logic cap_wr;
    logic [1:0] cap_sz;
    logic [31:0] cap_wd;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic ext_req;
    logic ext_msu;
    logic [31:0] dc;
    logic [31:0] dpc;
    logic [31:0] dinst;
    logic inst_v;
    logic [31:0] to_dbg;
    logic [31:0] to_cpu;
    logic cpu_full;
    logic emu_full;
    logic irq;
    logic [5:0][31:0] pbp;
    logic [1:0][31:0] dbp;
    logic dmode;
    logic mon;
    logic enter;
    logic [31:0] reg_rdata;
  } sbd_state_s;
endpackage

// ### test/sbd_dbg_model.sv
// behavioural debugger: drives the link in four phases
module sbd_dbg_model (
  output logic dbg_clk,
  output logic dbg_req,
  output logic [35:0] dbg_addr,
  output logic dbg_write,
  output logic [1:0] dbg_size,
  output logic [31:0] dbg_wdata,
  input wire logic dbg_ack,
  input wire logic dbg_err,
  input wire logic [31:0] dbg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    dbg_clk = 1'b0;
    dbg_req = 1'b0;
    dbg_addr = 36'h0;
    dbg_write = 1'b0;
    dbg_size = 2'h0;
    dbg_wdata = 32'h0;
  end

  // link clock only runs inside a transfer
  task automatic pulse();
    #40 dbg_clk = 1'b1;
    #40 dbg_clk = 1'b0;
  endtask

  // caller may pass misaligned halfword and word addresses; the bridge refuses them
  task automatic access(input logic [35:0] a, input logic w,
                        input logic [1:0] sz, input logic [31:0] wd,
                        output logic err, output logic [31:0] rd);
    int n;
    n = 0;
    dbg_addr = a;
    dbg_write = w;
    dbg_size = sz;
    dbg_wdata = wd;
    dbg_req = 1'b1;
    while (dbg_ack !== 1'b1 && n < 40) begin
      pulse();
      n++;
    end
    // a missing answer reads as unknown so the caller's compare trips
    err = n < 40 ? dbg_err : 1'bx;
    rd = dbg_rdata;
    dbg_req = 1'b0;
    n = 0;
    while (dbg_ack !== 1'b0 && n < 40) begin
      pulse();
      n++;
    end
    // released fields must not look valid
    dbg_addr = ~a;
    dbg_write = ~w;
    dbg_size = ~sz;
    dbg_wdata = ~wd;
  endtask
endmodule

// ### test/tb.sv
// testbench for the service bus debug access block
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, reset, ce, flash_secure, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, cpu_pc, cpu_daddr, ext_rdata, last_addr;
  logic cpu_pc_valid, cpu_dvalid, cpu_dbg_exit, ext_ack, last_msu;
  wire dbg_clk, dbg_req, dbg_write, dbg_ack, dbg_err, clk_wake, ext_req;
  wire ext_msu, ext_write, cpu_dbg_mode, cpu_monitor, cpu_dbg_enter;
  wire cpu_inst_valid, comm_irq, aux_en, aux_loc, debug_logic_clock_en;
  wire [35:0] dbg_addr;
  wire [1:0] dbg_size, ext_size;
  wire [31:0] dbg_wdata, dbg_rdata, ext_addr, ext_wdata, reg_rdata, cpu_inst;
  int fail_count, n_tests, cyc, enter_cnt, inst_cnt, irq_cnt, slow, ext_wait;
  int wake_cnt;
  logic [31:0] last_wd;
  logic [2:0] last_ctl;
  logic [4:0] s;
  logic d_err;
  logic [31:0] d_rd;

  sbd_debug u_dut (.sys_clk, .reset, .ce, .dbg_clk, .dbg_req, .dbg_addr,
    .dbg_write, .dbg_size, .dbg_wdata, .dbg_ack, .dbg_err, .dbg_rdata,
    .clk_wake, .ext_req, .ext_msu, .ext_addr, .ext_write, .ext_size,
    .ext_wdata, .ext_ack, .ext_rdata, .flash_secure, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cpu_pc, .cpu_pc_valid, .cpu_daddr,
    .cpu_dvalid, .cpu_dbg_exit, .cpu_dbg_mode, .cpu_monitor, .cpu_dbg_enter,
    .cpu_inst, .cpu_inst_valid, .comm_irq, .aux_en, .aux_loc,
    .debug_logic_clock_en);

  sbd_dbg_model u_dbg (.dbg_clk, .dbg_req, .dbg_addr, .dbg_write, .dbg_size,
    .dbg_wdata, .dbg_ack, .dbg_err, .dbg_rdata);

  always #4 sys_clk = ~sys_clk;

  // system bus slave; slow mode stalls the bridge
  always @(posedge sys_clk) begin
    ext_ack <= 1'b0;
    if (ext_req === 1'b1 && ext_ack !== 1'b1) begin
      if (ext_wait == 0) begin
        ext_ack <= 1'b1;
        ext_rdata <= ext_addr ^ 32'h5a5a0000;
        last_addr <= ext_addr;
        last_msu <= ext_msu;
        last_wd <= ext_wdata;
        last_ctl <= {ext_write, ext_size};
        ext_wait <= slow;
      end else begin
        ext_wait <= ext_wait - 1;
      end
    end
  end

  // pulse counters and hang guard
  always @(posedge sys_clk) begin
    if (cpu_dbg_enter === 1'b1) enter_cnt++;
    if (cpu_inst_valid === 1'b1) inst_cnt++;
    if (comm_irq === 1'b1) irq_cnt++;
    if (clk_wake === 1'b1) wake_cnt++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rw(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rr(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // debugger access; read data compared only when no error is expected
  task automatic dacc(input logic [35:0] a, input logic w,
                      input logic [1:0] sz, input logic [31:0] wd,
                      input logic ee, input logic [31:0] er);
    @(posedge sys_clk);
    #1 u_dbg.access(a, w, sz, wd, d_err, d_rd);
    chk({31'h0, d_err}, {31'h0, ee});
    if (ee === 1'b0 && w === 1'b0) chk(d_rd, er);
  endtask

  task automatic exit_dbg();
    @(posedge sys_clk);
    cpu_dbg_exit <= 1'b1;
    @(posedge sys_clk);
    cpu_dbg_exit <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    flash_secure = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_pc = 32'h00001234;
    cpu_pc_valid = 1'b1;
    cpu_daddr = 32'h0;
    cpu_dvalid = 1'b0;
    cpu_dbg_exit = 1'b0;
    slow = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 chk({31'h0, debug_logic_clock_en}, 32'h1);
    chk(wake_cnt, 0);
    rr(12'h008, 32'h00001000);
    dacc(36'h100000040, 1'b0, 2'h2, 32'h0, 1'b0, 32'h00001234);
    chk({31'h0, wake_cnt != 0}, 32'h1);
    dacc(36'h100000008, 1'b1, 2'h2, 32'h00001018, 1'b0, 32'h0);
    chk({30'h0, aux_en, aux_loc}, 32'h3);
    chk({31'h0, cpu_dbg_mode}, 32'h0);
    // every slave number; slow set on odd ones stalls the next external access (slave 6)
    for (s = 5'h0; s < 5'h10; s++) begin
      slow = s[0] ? 5 : 0;
      dacc({s[3:0], 32'h100}, 1'b0, 2'h2, 32'h0,
        !(s == 1 || s == 4 || s == 5 || s == 6),
        s == 1 ? 32'h0 : 32'h5a5a0100);
      if (s == 4 || s == 5 || s == 6) begin
        chk(last_addr, 32'h100);
        chk({31'h0, last_msu}, {31'h0, s == 6});
      end
    end
    slow = 0;
    dacc(36'h400000003, 1'b0, 2'h0, 32'h0, 1'b0, 32'h5a5a0003);
    chk({29'h0, last_ctl}, 32'h0);
    dacc(36'h400000002, 1'b0, 2'h1, 32'h0, 1'b0, 32'h5a5a0002);
    dacc(36'h400000001, 1'b0, 2'h1, 32'h0, 1'b1, 32'h0);
    dacc(36'h400000002, 1'b0, 2'h2, 32'h0, 1'b1, 32'h0);
    dacc(36'h400000000, 1'b0, 2'h3, 32'h0, 1'b1, 32'h0);
    dacc(36'h400000004, 1'b1, 2'h2, 32'h11223344, 1'b0, 32'h0);
    chk(last_wd, 32'h11223344);
    chk({29'h0, last_ctl}, 32'h6);
    rw(12'h008, 32'h00001c00);
    rw(12'h110, 32'hcafe0001);
    rr(12'h118, 32'h00000001);
    dacc(36'h100000110, 1'b0, 2'h2, 32'h0, 1'b0, 32'hcafe0001);
    chk(irq_cnt, 1);
    rr(12'h118, 32'h0);
    dacc(36'h100000114, 1'b1, 2'h2, 32'h13579bdf, 1'b0, 32'h0);
    chk(irq_cnt, 2);
    rr(12'h118, 32'h00000002);
    rr(12'h114, 32'h13579bdf);
    rr(12'h118, 32'h0);
    @(posedge sys_clk);
    ce <= 1'b0;
    rw(12'h110, 32'hdeadbeef);
    ce <= 1'b1;
    rr(12'h118, 32'h0);
    @(posedge sys_clk);
    flash_secure <= 1'b1;
    rw(12'h110, 32'h0badf00d);
    dacc(36'h100000110, 1'b0, 2'h2, 32'h0, 1'b0, 32'h0badf00d);
    dacc(36'h100000114, 1'b1, 2'h2, 32'h1, 1'b0, 32'h0);
    dacc(36'h100000008, 1'b0, 2'h2, 32'h0, 1'b1, 32'h0);
    dacc(36'h100000008, 1'b1, 2'h2, 32'h1002, 1'b1, 32'h0);
    chk({31'h0, cpu_dbg_mode}, 32'h0);
    dacc(36'h580800000, 1'b0, 2'h2, 32'h0, 1'b0, 32'hdada0000);
    dacc(36'h580800000, 1'b1, 2'h2, 32'h0, 1'b1, 32'h0);
    dacc(36'h581000000, 1'b0, 2'h2, 32'h0, 1'b1, 32'h0);
    @(posedge sys_clk);
    flash_secure <= 1'b0;
    dacc(36'h100000008, 1'b1, 2'h2, 32'h1002, 1'b0, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, cpu_dbg_mode, cpu_monitor}, 32'h2);
    chk(enter_cnt, 1);
    dacc(36'h100000104, 1'b1, 2'h2, 32'he1b00001, 1'b0, 32'h0);
    chk(inst_cnt, 1);
    chk(cpu_inst, 32'he1b00001);
    exit_dbg();
    chk({31'h0, cpu_dbg_mode}, 32'h0);
    rw(12'h214, 32'h00002001);
    @(posedge sys_clk);
    cpu_pc <= 32'h00002000;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, cpu_dbg_mode}, 32'h1);
    chk(enter_cnt, 2);
    cpu_pc <= 32'h00001234;
    exit_dbg();
    rw(12'h008, 32'h00001101);
    rr(12'h008, 32'h00001101);
    rw(12'h240, 32'h20000010);
    @(posedge sys_clk);
    cpu_daddr <= 32'h20000010;
    cpu_dvalid <= 1'b1;
    @(posedge sys_clk);
    cpu_dvalid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({30'h0, cpu_dbg_mode, cpu_monitor}, 32'h3);
    dacc(36'h100000104, 1'b1, 2'h2, 32'h1, 1'b0, 32'h0);
    chk(inst_cnt, 1);
    exit_dbg();
    test_done();
  end
endmodule
